// ---- verilog/css_pkg.sv ----
// Purpose: Shared constants for the clock source selector.
// Assumes: APB with 32-bit data, byte addresses, 50 MHz pclk.
// Notes:   Register offsets, field positions, reset values, timing.
package css_pkg;

  // Register byte offsets.
  localparam logic [7:0] CSS_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSS_OFF_MULT = 8'h04;
  localparam logic [7:0] CSS_OFF_TRIM = 8'h08;

  // Control register field positions.
  localparam int CSS_B_SEL  = 0;
  localparam int CSS_B_MON  = 1;
  localparam int CSS_B_IGEN = 2;
  localparam int CSS_B_EGEN = 3;
  localparam int CSS_B_ISTB = 4;
  localparam int CSS_B_ESTB = 5;

  // Reset values and factor constants.
  localparam logic [6:0] CSS_MULT_RST = 7'h15;
  localparam logic [6:0] CSS_MULT_ONE = 7'h01;
  localparam logic [6:0] CSS_MULT_ZERO = 7'h00;
  localparam logic [7:0] CSS_TRIM_RST = 8'h80;

  // Frequency check: base rate, bus clock rate and measuring window.
  localparam longint CSS_BASE_HZ  = 307200;
  localparam longint CSS_PCLK_HZ  = 50000000;
  localparam int     CSS_WIN_CYC  = 15625;
  localparam longint CSS_EDGES_PER_N = (CSS_BASE_HZ * CSS_WIN_CYC) / CSS_PCLK_HZ;
  localparam int     CSS_TOL_PCT  = 5;
  localparam int     CSS_PCT_FULL = 100;

  // External startup delay in external clock cycles.
  localparam logic [12:0] CSS_EXT_START = 13'h1000;

  // Bus answer states, one-hot.
  typedef enum logic [1:0] {
    CSS_IDLE = 2'b01,
    CSS_RESP = 2'b10
  } css_bus_t;

endpackage

// ---- verilog/css_sw_if.sv ----
// Purpose: Signals between the selector core and a clock switch.
// Assumes: All signals are levels sampled on pclk.
// Notes:   One instance per switch.
`timescale 1ns/10ps
interface css_sw_if;
  logic clk_int;
  logic clk_ext;
  logic sel;
  logic mon;
  logic int_lost;
  logic ext_lost;
  logic clk_out;

  modport ctrl (output clk_int, output clk_ext, output sel, output mon,
                output int_lost, output ext_lost, input clk_out);
  modport sw   (input clk_int, input clk_ext, input sel, input mon,
                input int_lost, input ext_lost, output clk_out);
endinterface

// ---- verilog/css_clk_switch.sv ----
// Purpose: Glitch-free switch between the internal and external clock.
// Assumes: Both clocks are oversampled levels synchronous to pclk.
// Notes:   Side 0 is internal, side 1 external; reset selects side 0.
`timescale 1ns/10ps
module css_clk_switch
  import css_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  css_sw_if.sw     sw
);

  logic [1:0] clk_s;
  logic [1:0] prev_q;
  logic [1:0] fall;
  logic [1:0] lost;
  logic [1:0] want;
  logic [1:0] stg1_q;
  logic [1:0] stg2_q;
  logic       sel_eff;
  logic       out_q;

  // A lost side is forced off; the live side is chosen instead.
  assign clk_s   = {sw.clk_ext, sw.clk_int};
  assign fall    = prev_q & ~clk_s;
  assign lost    = {sw.mon & sw.ext_lost, sw.mon & sw.int_lost};
  assign sel_eff = lost[0] ? 1'b1 : (lost[1] ? 1'b0 : sw.sel);
  assign want    = {sel_eff, ~sel_eff};

  // Sample history of both clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 2'b00;
    end else if (clk_en) begin
      prev_q <= clk_s;
    end
  end

  // Each side steps its enable through two stages on its own falling edges.
  for (genvar g = 0; g < 2; g++) begin : g_side
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stg1_q[g] <= (g == 0);
        stg2_q[g] <= (g == 0);
      end else if (clk_en) begin
        if (lost[g]) begin
          stg1_q[g] <= 1'b0;
          stg2_q[g] <= 1'b0;
        end else if (fall[g]) begin
          stg1_q[g] <= want[g] & ~stg2_q[1-g];
          stg2_q[g] <= stg1_q[g];
        end
      end
    end
  end

  // Output is the enabled clock, low while neither side is enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (clk_en) begin
      out_q <= |(clk_s & stg2_q);
    end
  end

  assign sw.clk_out = out_q;

endmodule

// ---- verilog/css_clock_source_selector.sv ----
// Purpose: Clock source selection, generator enables and stable flags.
// Assumes: Oscillator clocks and loss flags are synchronous to pclk.
// Notes:   APB slave with one wait state; clk_en low freezes all state.
// Notes:   A write lands at the edge that completes the transfer.
// Notes on behaviour
// - Oscillator output uses external clock when select is 1, else internal.
// - Select changes only with both generators on and target stable.
// - Generator output clock is the selected clock divided by two.
// - Timebase switch picks external clock whenever external enable is set.
// - Switch runs old clock 1-2 cycles, low 1-2 new, then new.
// - Reset makes both switches select the internal clock.
// - Monitor on and a side lost forces the live side.
// - Internal enable clears only after select set, monitor clear one cycle.
// - Internal enable forced on with monitor, select clear, or reset.
// - Internal stable sets when internal clock is within about 5 percent.
// - Internal stable cleared on loss, disable, multiplier/trim write, stop without keep, reset.
// - External enable clears only after select and monitor clear one cycle.
// - External enable forced on by monitor or select; off at reset.
// - External stable sets after 4096 external cycles since enable.
// - External stable cleared on loss, disable, stop without keep, reset.
// - Internal clock runs at 307.2 kHz base times the factor.
// - A factor of zero acts as one.
// - Multiplier writes are ignored while the monitor is on.
// - Reset loads the factor with 21.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module css_clock_source_selector
  import css_pkg::*;
#(
  parameter int WIN_CYC = CSS_WIN_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_osc_clock,
  input  wire logic        external_osc_clock,
  input  wire logic        internal_clock_lost,
  input  wire logic        external_clock_lost,
  input  wire logic        stop_mode,
  input  wire logic        osc_keep_in_stop,
  output logic             osc_output_clock,
  output logic             timebase_clock,
  output logic             generator_output_clock,
  output logic      [6:0]  multiplier_factor,
  output logic      [7:0]  clock_trim,
  output logic             internal_gen_enable,
  output logic             external_gen_enable
);

  // Address match used by every register decode.
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  css_bus_t    st_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        cs_q;
  logic        mon_q;
  logic        igen_q;
  logic        egen_q;
  logic        istb_q;
  logic        estb_q;
  logic        ok_i_q;
  logic        ok_e_q;
  logic [6:0]  mult_q;
  logic [7:0]  trim_q;
  logic [6:0]  fact_q;
  logic        ic_q;
  logic        ec_q;
  logic [15:0] win_q;
  logic [13:0] icnt_q;
  logic [12:0] ecnt_q;
  logic        oprev_q;
  logic        gen_q;

  // Access decode; the request is taken in its first access cycle and
  // commits in its second, the cycle in which pready stands high.
  logic        take;
  logic        commit;
  logic        hit_ctrl;
  logic        hit_mult;
  logic        hit_trim;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_mult;
  logic        wr_trim;
  logic [31:0] rd_val;
  logic [31:0] ctrl_val;

  assign take     = (st_q == CSS_IDLE) & psel & penable;
  assign commit   = (st_q == CSS_RESP) & psel & penable;
  assign hit_ctrl = reg_hit(paddr, CSS_OFF_CTRL);
  assign hit_mult = reg_hit(paddr, CSS_OFF_MULT);
  assign hit_trim = reg_hit(paddr, CSS_OFF_TRIM);
  assign mapped   = hit_ctrl | hit_mult | hit_trim;
  // Writes wait for the completing edge, so no effect shows before pready.
  assign wr_ctrl  = commit & pwrite & hit_ctrl;
  assign wr_mult  = commit & pwrite & hit_mult & ~mon_q;
  assign wr_trim  = commit & pwrite & hit_trim;

  // Read data selection; unused bits read as zero.
  always_comb begin
    ctrl_val             = 32'h0000_0000;
    ctrl_val[CSS_B_SEL]  = cs_q;
    ctrl_val[CSS_B_MON]  = mon_q;
    ctrl_val[CSS_B_IGEN] = igen_q;
    ctrl_val[CSS_B_EGEN] = egen_q;
    ctrl_val[CSS_B_ISTB] = istb_q;
    ctrl_val[CSS_B_ESTB] = estb_q;
  end

  assign rd_val = hit_ctrl ? ctrl_val :
                  hit_mult ? {25'h000_0000, mult_q} :
                  hit_trim ? {24'h00_0000, trim_q} : 32'h0000_0000;

  // Bus answer: pready is high for exactly one cycle after the take.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= CSS_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      // Read data is captured at the take and stands with pready.
      case (st_q)
        CSS_IDLE: begin
          if (take) begin
            st_q      <= CSS_RESP;
            pready_q  <= 1'b1;
            pslverr_q <= ~mapped;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_val;
          end
        end
        CSS_RESP: begin
          st_q      <= CSS_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          st_q     <= CSS_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // Next control values with the forced cases applied last.
  logic cs_ok;
  logic cs_d;
  logic mon_d;
  logic igen_d;
  logic egen_d;

  // A select write whose target is not enabled and stable leaves the select as it was.
  // Software gets no error for it and must read the bit back.
  assign cs_ok  = igen_q & egen_q & (pwdata[CSS_B_SEL] ? estb_q : istb_q);
  assign cs_d   = (wr_ctrl & cs_ok) ? pwdata[CSS_B_SEL] : cs_q;
  assign mon_d  = wr_ctrl ? pwdata[CSS_B_MON] : mon_q;
  assign igen_d = (mon_d | ~cs_d) ? 1'b1 :
                  wr_ctrl ? (pwdata[CSS_B_IGEN] | ~(ok_i_q & cs_q & ~mon_q)) :
                  igen_q;
  assign egen_d = (mon_d | cs_d) ? 1'b1 :
                  wr_ctrl ? (pwdata[CSS_B_EGEN] | ~(ok_e_q & ~cs_q & ~mon_q)) :
                  egen_q;

  // Control register and the one-cycle hold qualifiers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q   <= 1'b0;
      mon_q  <= 1'b0;
      igen_q <= 1'b1;
      egen_q <= 1'b0;
      ok_i_q <= 1'b0;
      ok_e_q <= 1'b0;
    end else if (clk_en) begin
      cs_q   <= cs_d;
      mon_q  <= mon_d;
      igen_q <= igen_d;
      egen_q <= egen_d;
      // The qualifiers hold last cycle's select and monitor, so a clear needs a full cycle.
      ok_i_q <= cs_q & ~mon_q;
      ok_e_q <= ~cs_q & ~mon_q;
    end
  end

  // Multiplier and trim registers; the factor output maps zero to one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_q <= CSS_MULT_RST;
      trim_q <= CSS_TRIM_RST;
      fact_q <= CSS_MULT_RST;
    end else if (clk_en) begin
      if (wr_mult) begin
        mult_q <= pwdata[6:0];
      end
      if (wr_trim) begin
        trim_q <= pwdata[7:0];
      end
      // The effective factor lags the register by one cycle.
      fact_q <= (mult_q == CSS_MULT_ZERO) ? CSS_MULT_ONE : mult_q;
    end
  end

  // Stable flag clear conditions.
  logic stop_off;
  logic iclr;
  logic eclr;
  logic iedge;
  logic eedge;

  assign stop_off = stop_mode & ~osc_keep_in_stop;
  assign iclr     = (mon_q & internal_clock_lost) | ~igen_q | wr_mult | wr_trim | stop_off;
  assign eclr     = (mon_q & external_clock_lost) | ~egen_q | stop_off;
  assign iedge    = internal_osc_clock & ~ic_q;
  assign eedge    = external_osc_clock & ~ec_q;

  // Frequency check: edges over the window against factor times base.
  // The expected count is fixed, so a shortened window needs a faster internal clock.
  logic [13:0] exp_n;
  logic [13:0] diff;
  logic        in_tol;
  logic        win_end;

  assign exp_n   = 14'(fact_q) * 14'(CSS_EDGES_PER_N);
  assign diff    = (icnt_q > exp_n) ? (icnt_q - exp_n) : (exp_n - icnt_q);
  assign in_tol  = (21'(diff) * 21'(CSS_PCT_FULL)) <= (21'(exp_n) * 21'(CSS_TOL_PCT));
  assign win_end = (win_q == 16'(WIN_CYC - 1));

  // Internal measurement and stable flag.
  // Every clear restarts the window, so a partial window never sets the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ic_q   <= 1'b0;
      win_q  <= 16'h0000;
      icnt_q <= 14'h0000;
      istb_q <= 1'b0;
    end else if (clk_en) begin
      ic_q <= internal_osc_clock;
      if (iclr) begin
        win_q  <= 16'h0000;
        icnt_q <= 14'h0000;
        istb_q <= 1'b0;
      end else if (win_end) begin
        win_q  <= 16'h0000;
        icnt_q <= 14'h0000;
        istb_q <= in_tol;
      end else begin
        win_q <= win_q + 16'h0001;
        if (iedge && icnt_q != 14'h3fff) begin
          icnt_q <= icnt_q + 14'h0001;
        end
      end
    end
  end

  // External startup counter and stable flag.
  // A clock that stops before the count completes keeps the flag clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ec_q   <= 1'b0;
      ecnt_q <= 13'h0000;
      estb_q <= 1'b0;
    end else if (clk_en) begin
      ec_q <= external_osc_clock;
      if (eclr) begin
        ecnt_q <= 13'h0000;
        estb_q <= 1'b0;
      end else if (ecnt_q >= CSS_EXT_START) begin
        estb_q <= 1'b1;
      end else if (eedge) begin
        ecnt_q <= ecnt_q + 13'h0001;
      end
    end
  end

  // Two switches: oscillator output and timebase.
  // The timebase switch follows the external enable rather than the select bit.
  css_sw_if osc_if ();
  css_sw_if tb_if ();

  assign osc_if.clk_int  = internal_osc_clock;
  assign osc_if.clk_ext  = external_osc_clock;
  assign osc_if.sel      = cs_q;
  assign osc_if.mon      = mon_q;
  assign osc_if.int_lost = internal_clock_lost;
  assign osc_if.ext_lost = external_clock_lost;
  assign tb_if.clk_int   = internal_osc_clock;
  assign tb_if.clk_ext   = external_osc_clock;
  assign tb_if.sel       = egen_q;
  assign tb_if.mon       = mon_q;
  assign tb_if.int_lost  = internal_clock_lost;
  assign tb_if.ext_lost  = external_clock_lost;

  css_clk_switch u_osc_sw (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .sw      (osc_if.sw)
  );

  css_clk_switch u_tb_sw (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .sw      (tb_if.sw)
  );

  // Divide-by-two toggles on each rising edge of the oscillator output.
  // It reads the registered switch output, so it lags that output by one pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oprev_q <= 1'b0;
      gen_q   <= 1'b0;
    end else if (clk_en) begin
      oprev_q <= osc_if.clk_out;
      if (osc_if.clk_out && !oprev_q) begin
        gen_q <= ~gen_q;
      end
    end
  end

  // Outputs, each straight from a flip-flop.
  // The switch outputs are registered inside each switch.
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign osc_output_clock       = osc_if.clk_out;
  assign timebase_clock         = tb_if.clk_out;
  assign generator_output_clock = gen_q;
  assign multiplier_factor      = fact_q;
  assign clock_trim             = trim_q;
  assign internal_gen_enable    = igen_q;
  assign external_gen_enable    = egen_q;

endmodule

// ---- testbench/css_selector_properties.sv ----
// Purpose: Port-level checks for the clock source selector.
// Assumes: One pclk domain; presetn is active low.
// Notes:   Bound to the top module and watching its outputs.
`timescale 1ns/10ps
module css_selector_properties
  import css_pkg::*;
#(
  parameter int WIN_CYC = CSS_WIN_CYC
)
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       osc_output_clock,
  input wire logic       generator_output_clock,
  input wire logic [6:0] multiplier_factor,
  input wire logic       internal_gen_enable,
  input wire logic       external_gen_enable
);
  // Write accesses on the bus to the control and multiplier registers.
  wire logic wr_ctrl = psel && penable && pwrite && (paddr == CSS_OFF_CTRL);
  wire logic wr_mult = psel && penable && pwrite && (paddr == CSS_OFF_MULT);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_state: assert property (
    $rose(presetn) |-> internal_gen_enable && !external_gen_enable && multiplier_factor == CSS_MULT_RST)
    else $error("Reset state wrong.");
  a_int_en_forced: assert property (!external_gen_enable |-> internal_gen_enable)
    else $error("Internal enable not forced.");
  a_factor_nonzero: assert property (multiplier_factor != CSS_MULT_ZERO)
    else $error("Factor shows zero.");
  a_factor_by_write: assert property ($changed(multiplier_factor) |-> $past(wr_mult, 2))
    else $error("Factor changed without a write.");
  a_enable_by_write: assert property (
    $changed(internal_gen_enable) || $changed(external_gen_enable) |-> $past(wr_ctrl))
    else $error("Enable changed without a write.");
  a_div_quiet: assert property (
    osc_output_clock == $past(osc_output_clock) && osc_output_clock == $past(osc_output_clock, 2)
    |-> $stable(generator_output_clock))
    else $error("Divided clock moved alone.");
  a_answer_wait: assert property (psel && penable && !pready |=> pready)
    else $error("Answer late.");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle.");
  a_err_unmapped: assert property (pready && paddr > CSS_OFF_TRIM |-> pslverr)
    else $error("Unmapped access not refused.");
endmodule
bind css_clock_source_selector css_selector_properties #(.WIN_CYC(WIN_CYC)) i_css_selector_properties (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .osc_output_clock,
  .generator_output_clock, .multiplier_factor, .internal_gen_enable, .external_gen_enable);

// ---- testbench/css_clock_source_selector_tb_top.sv ----
// Purpose: Self-checking bench for the clock source selector.
// Assumes: APB master tasks; the internal oscillator runs free, the external one stops while lost.
// Notes:   Short window; the internal clock fits a factor of one.
`timescale 1ns/10ps
module css_clock_source_selector_tb_top import css_pkg::*;;
  localparam logic [31:0] M_SEL = 32'h0000_0001 << CSS_B_SEL;
  localparam logic [31:0] M_MON = 32'h0000_0001 << CSS_B_MON;
  localparam logic [31:0] M_IEN = 32'h0000_0001 << CSS_B_IGEN;
  localparam logic [31:0] M_EEN = 32'h0000_0001 << CSS_B_EGEN;
  localparam logic [31:0] M_IST = 32'h0000_0001 << CSS_B_ISTB;
  localparam logic [31:0] M_EST = 32'h0000_0001 << CSS_B_ESTB;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        int_q = 1'b0;
  logic        ext_q = 1'b0;
  logic        internal_osc_clock;
  logic        external_osc_clock;
  logic        internal_clock_lost = 1'b0;
  logic        external_clock_lost = 1'b0;
  logic        stop_mode = 1'b0;
  logic        osc_keep_in_stop = 1'b0;
  logic        osc_output_clock;
  logic        timebase_clock;
  logic        generator_output_clock;
  logic [6:0]  multiplier_factor;
  logic [7:0]  clock_trim;
  logic        internal_gen_enable;
  logic        external_gen_enable;
  logic [2:0]  last_q = 3'b000;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n_o = 0;
  int          n_t = 0;
  int          n_g = 0;
  int          d_o;
  int          d_t;
  int          d_g;
  time         t0;

  css_clock_source_selector #(.WIN_CYC(625)) i_css_clock_source_selector (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .internal_osc_clock, .external_osc_clock, .internal_clock_lost, .external_clock_lost, .stop_mode,
    .osc_keep_in_stop, .osc_output_clock, .timebase_clock, .generator_output_clock, .multiplier_factor,
    .clock_trim, .internal_gen_enable, .external_gen_enable);

  // Bus clock, then oscillators offset so no edge meets a pclk edge.
  always #10 pclk = ~pclk;
  initial begin
    #0.03;
    forever #65.1 int_q = ~int_q;
  end
  initial begin
    #7;
    forever #30 ext_q = ~ext_q;
  end
  // A lost external oscillator really stops.
  assign internal_osc_clock = int_q;
  assign external_osc_clock = ext_q & ~external_clock_lost;

  // Rising edges of the three output clocks, plus the hang guard.
  always @(posedge pclk) begin
    last_q <= {osc_output_clock, timebase_clock, generator_output_clock};
    n_o <= n_o + int'(osc_output_clock && !last_q[2]);
    n_t <= n_t + int'(timebase_clock && !last_q[1]);
    n_g <= n_g + int'(generator_output_clock && !last_q[0]);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic inr(input int seen, input int lo, input int hi);
    chk(32'((seen >= lo) && (seen <= hi)), 32'h0000_0001);
  endtask

  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e);
  endtask

  // Polls the control register until a status bit sets.
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, CSS_OFF_CTRL, 32'h0000_0000);
      n++;
    end while ((rdat & m) == 32'h0000_0000 && n < 8000);
    chk(rdat & m, m);
  endtask

  // Counts output clock edges over 300 cycles after settling.
  task automatic meas();
    int o;
    int t;
    int g;
    repeat (20) @(posedge pclk);
    o = n_o;
    t = n_t;
    g = n_g;
    repeat (300) @(posedge pclk);
    d_o = n_o - o;
    d_t = n_t - t;
    d_g = n_g - g;
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({25'h0, multiplier_factor}, {25'h0, CSS_MULT_RST});
    chk({30'h0, internal_gen_enable, external_gen_enable}, 32'h0000_0002);
    rd(CSS_OFF_CTRL, 32'h0000_003F, M_IEN);
    rd(CSS_OFF_MULT, 32'h0000_007F, 32'h0000_0015);
    rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    apb(1'b1, CSS_OFF_CTRL, M_SEL | M_IEN);
    rd(CSS_OFF_CTRL, 32'h0000_000F, M_IEN);
    apb(1'b1, CSS_OFF_MULT, 32'h0000_0000);
    // The factor output follows the register one cycle later.
    @(posedge pclk);
    chk({25'h0, multiplier_factor}, 32'h0000_0001);
    apb(1'b1, CSS_OFF_CTRL, M_IEN | M_EEN);
    t0 = $time;
    rd(CSS_OFF_CTRL, M_EST, 32'h0000_0000);
    meas();
    inr(d_t, 97, 103);
    inr(d_o, 44, 48);
    inr(d_g, 21, 25);
    poll(M_IST);
    poll(M_EST);
    chk(32'(($time - t0) >= 64'd245760), 32'h0000_0001);
    apb(1'b1, CSS_OFF_MULT, 32'h0000_0000);
    rd(CSS_OFF_CTRL, M_IST, 32'h0000_0000);
    apb(1'b1, CSS_OFF_CTRL, M_SEL | M_IEN | M_EEN);
    rd(CSS_OFF_CTRL, M_SEL, M_SEL);
    meas();
    inr(d_o, 97, 103);
    inr(d_g, 48, 52);
    apb(1'b1, CSS_OFF_CTRL, M_SEL | M_EEN);
    rd(CSS_OFF_CTRL, M_IEN | M_IST, 32'h0000_0000);
    apb(1'b1, CSS_OFF_CTRL, M_SEL | M_MON | M_EEN);
    rd(CSS_OFF_CTRL, M_IEN, M_IEN);
    apb(1'b1, CSS_OFF_MULT, 32'h0000_0005);
    rd(CSS_OFF_MULT, 32'h0000_007F, 32'h0000_0000);
    apb(1'b1, CSS_OFF_CTRL, M_SEL | M_MON);
    rd(CSS_OFF_CTRL, M_EEN, M_EEN);
    external_clock_lost <= 1'b1;
    meas();
    inr(d_o, 44, 48);
    rd(CSS_OFF_CTRL, M_EST, 32'h0000_0000);
    external_clock_lost <= 1'b0;
    poll(M_IST);
    apb(1'b1, CSS_OFF_TRIM, 32'h0000_005A);
    chk({24'h0, clock_trim}, 32'h0000_005A);
    rd(CSS_OFF_CTRL, M_IST, 32'h0000_0000);
    poll(M_IST);
    osc_keep_in_stop <= 1'b1;
    stop_mode <= 1'b1;
    rd(CSS_OFF_CTRL, M_IST, M_IST);
    osc_keep_in_stop <= 1'b0;
    rd(CSS_OFF_CTRL, M_IST, 32'h0000_0000);
    clk_en <= 1'b0;
    meas();
    inr(d_o, 0, 0);
    clk_en <= 1'b1;
    report_and_stop();
  end
endmodule
